// ### dxc_bus_model.sv
// Bus-side model that takes read and write commands and returns one word per read.
`timescale 1ns/1ps
module dxc_bus_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Slow mode adds three wait cycles to every answer except a read command that directly follows a write with no gap.
  input wire logic slow,
  // Command and data lines.
  input wire logic rcmd_valid,
  output logic rcmd_ready,
  output logic rdat_valid,
  output logic [31:0] rdat,
  input wire logic wcmd_valid,
  output logic wcmd_ready
);
  logic [3:0] cnt;
  logic rd_wait;
  logic go;

  // Answers are one-cycle pulses, so a stuck valid would be seen as a second command.
  assign go = cnt >= (slow ? 4'h3 : 4'h0);

  // Data outside its pulse is scrambled so that a late capture shows up.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {cnt, rd_wait, rcmd_ready, wcmd_ready, rdat_valid} <= '0;
      rdat <= 32'h5a5a_0000;
    end else begin
      rcmd_ready <= 1'b0;
      wcmd_ready <= 1'b0;
      rdat_valid <= 1'b0;
      rdat <= ~rdat;
      cnt <= (rcmd_valid || wcmd_valid || rd_wait) ? cnt + 4'h1 : 4'h0;
      if (rcmd_valid && rcmd_ready) begin
        rd_wait <= 1'b1;
        cnt <= 4'h0;
      end else if (rcmd_valid && go) begin
        rcmd_ready <= 1'b1;
      end
      if (rd_wait && go) begin
        rdat_valid <= 1'b1;
        rdat <= 32'hc0de_0001;
        rd_wait <= 1'b0;
        cnt <= 4'h0;
      end
      if (wcmd_valid && !wcmd_ready && go) wcmd_ready <= 1'b1;
    end
  end
endmodule : dxc_bus_model

// ### dxc_idle.sv
// Clock-stop acknowledge logic for one controller.
`timescale 1ns/1ps
module dxc_idle
  import dxc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Handshake.
  dxc_idle_if.ctl hs
);

  typedef struct packed {
    logic ack;
    logic rise;
  } dxc_idle_s;

  dxc_idle_s st_r;
  dxc_idle_s st_nxt;

  // Acknowledge once idle, then hold it until the request drops.
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = hs.stop_req && (st_r.ack || hs.conds_ok);
    st_nxt.rise = hs.stop_req && hs.conds_ok && !st_r.ack;
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hs.stop_ack = st_r.ack;
  assign hs.ack_rise = st_r.rise;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_ACK_NEEDS_IDLE: assert property ($rose(hs.stop_ack) |-> $past(hs.conds_ok))
    else $error("stop acknowledge rose without idle conditions");
  AST_ACK_HOLDS: assert property (hs.stop_ack && hs.stop_req |=> hs.stop_ack)
    else $error("stop acknowledge dropped while request held");
  AST_ACK_RELEASE: assert property (!hs.stop_req |=> !hs.stop_ack)
    else $error("stop acknowledge stayed after request withdrawn");

endmodule : dxc_idle

// ### dxc_idle_if.sv
// Clock-stop handshake signals between the top and one idle controller.
`timescale 1ns/1ps
interface dxc_idle_if;
  logic stop_req;
  logic conds_ok;
  logic stop_ack;
  logic ack_rise;

  modport ctl (input stop_req, input conds_ok, output stop_ack, output ack_rise);
  modport host (output stop_req, output conds_ok, input stop_ack, input ack_rise);
endinterface : dxc_idle_if

// ### dxc_pkg.sv
// Shared constants, register map and state encoding for the transfer issue and idle block.
package dxc_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] DXC_OFF_CTRL = 8'h00;
  localparam logic [7:0] DXC_OFF_GAP = 8'h04;
  localparam logic [7:0] DXC_OFF_DIM = 8'h08;
  localparam logic [7:0] DXC_OFF_INDEX = 8'h0c;
  localparam logic [7:0] DXC_OFF_MODE = 8'h10;
  localparam logic [7:0] DXC_OFF_SRC = 8'h14;
  localparam logic [7:0] DXC_OFF_DST = 8'h18;
  localparam logic [7:0] DXC_OFF_CC_ST = 8'h1c;
  localparam logic [7:0] DXC_OFF_TC_ST = 8'h20;
  localparam logic [7:0] DXC_OFF_IRQ_ST = 8'h24;
  localparam logic [7:0] DXC_OFF_IRQ_MASK = 8'h28;

  // Field positions inside the control register.
  localparam int DXC_CTRL_CC_EN = 0;
  localparam int DXC_CTRL_TC_EN = 1;
  localparam int DXC_CTRL_START = 2;
  localparam int DXC_CTRL_PRIO_LSB = 8;

  // Field positions inside the mode register.
  localparam int DXC_MODE_SRC = 0;
  localparam int DXC_MODE_DST = 1;
  localparam int DXC_MODE_DBS_LSB = 16;

  // Interrupt status bit positions.
  localparam int DXC_IRQ_DONE = 0;
  localparam int DXC_IRQ_CC_IDLE = 1;
  localparam int DXC_IRQ_TC_IDLE = 2;
  localparam int DXC_IRQ_W = 3;

  // Values after reset.
  localparam logic [15:0] DXC_RST_GAP = 16'h0000;
  localparam logic [15:0] DXC_RST_DBS = 16'h0040;
  localparam logic [2:0] DXC_RST_PRIO = 3'h0;
  localparam logic [2:0] DXC_RST_IRQ_MASK = 3'h0;

  // Linearisation limit on the second-dimension count, and the increment address mode.
  localparam logic [15:0] DXC_LIN_MAX_CNT = 16'h03ff;
  localparam logic DXC_AM_INCR = 1'b0;

  // AXI response codes.
  localparam logic [1:0] DXC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DXC_RESP_SLVERR = 2'h2;

  // Transfer engine states.
  typedef enum logic [2:0] {
    DXC_S_IDLE,
    DXC_S_RD_CMD,
    DXC_S_RD_DATA,
    DXC_S_WR_CMD,
    DXC_S_GAP
  } dxc_state_e;

endpackage : dxc_pkg

// ### dxc_top.sv
// Transfer issue engine with read pacing, clock-stop handshakes and AXI4-Lite registers.
`timescale 1ns/1ps
module dxc_top
  import dxc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite slave.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Read command port.
  output logic rcmd_valid,
  input wire logic rcmd_ready,
  output logic [31:0] rcmd_addr,
  output logic [31:0] rcmd_bytes,
  input wire logic rdat_valid,
  input wire logic [31:0] rdat,
  // Write command port, data travels with the command.
  output logic wcmd_valid,
  input wire logic wcmd_ready,
  output logic [31:0] wcmd_addr,
  output logic [31:0] wcmd_bytes,
  output logic [31:0] wcmd_data,
  // Channel controller activity.
  input wire logic cc_evt_pending,
  input wire logic cc_queue_busy,
  input wire logic cc_tr_active,
  input wire logic cc_compl_pending,
  output logic cc_enable,
  // Power controller handshakes.
  input wire logic cc_stop_req,
  output logic cc_stop_ack,
  input wire logic tc_stop_req,
  output logic tc_stop_ack,
  // System side.
  output logic [2:0] master_prio,
  output logic irq
);

  typedef struct packed {
    dxc_state_e state;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cc_en;
    logic tc_en;
    logic [2:0] prio;
    logic [15:0] gap;
    logic [15:0] default_burst_size;
    logic [15:0] fdb;
    logic [15:0] sdc;
    logic [15:0] sidx;
    logic [15:0] didx;
    logic smode;
    logic dmode;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] cur_src;
    logic [31:0] cur_dst;
    logic [31:0] cmd_bytes;
    logic [31:0] wdat;
    logic [15:0] cmds_left;
    logic [15:0] gap_cnt;
    logic lin;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
  } dxc_top_s;

  dxc_top_s st_r;
  dxc_top_s st_nxt;
  dxc_idle_if cc_if ();
  dxc_idle_if tc_if ();
  logic bus_busy;
  logic lin_c;
  logic start_ok;
  logic wr_hs;

  // Byte-lane merge for AXI write strobes.
  function automatic logic [31:0] dxc_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : dxc_merge

  // Idle conditions; any bus access in flight keeps the channel side awake.
  assign bus_busy = st_r.aw_have || st_r.w_have || st_r.bvalid || st_r.rvalid ||
                    s_axi_awvalid || s_axi_wvalid || s_axi_arvalid;
  assign cc_if.stop_req = cc_stop_req;
  assign cc_if.conds_ok = !(cc_evt_pending || cc_queue_busy || cc_tr_active ||
                            cc_compl_pending || bus_busy);
  assign tc_if.stop_req = tc_stop_req;
  assign tc_if.conds_ok = (st_r.state == DXC_S_IDLE);

  // Two independent handshakes, one per controller.
  dxc_idle u_cc_idle (.mclk(mclk), .rst(rst), .hs(cc_if));
  dxc_idle u_tc_idle (.mclk(mclk), .rst(rst), .hs(tc_if));

  // Linearisation test on the loaded parameter set.
  assign lin_c = (st_r.fdb <= st_r.default_burst_size) && (st_r.fdb != 16'h0000) &&
                 ((st_r.fdb & (st_r.fdb - 16'h0001)) == 16'h0000) &&
                 (st_r.sidx == st_r.fdb) && (st_r.didx == st_r.fdb) &&
                 (st_r.sdc <= DXC_LIN_MAX_CNT) &&
                 (st_r.smode == DXC_AM_INCR) && (st_r.dmode == DXC_AM_INCR);
  assign wr_hs = wcmd_valid && wcmd_ready;

  // Next-state logic: register slave, start decode and the transfer engine.
  always_comb begin
    logic [31:0] wtmp;
    logic [31:0] rd_val;
    logic start_req;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    wtmp = 32'h0000_0000;
    rd_val = 32'h0000_0000;
    start_req = 1'b0;
    irq_set = 3'h0;
    irq_clr = 3'h0;
    st_nxt = st_r;
    // Accept address and data independently, in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_have && st_r.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = DXC_RESP_OKAY;
      unique case (st_r.awaddr)
        DXC_OFF_CTRL: begin
          wtmp = dxc_merge({21'h0, st_r.prio, 6'h0, st_r.tc_en, st_r.cc_en},
                           st_r.wdata, st_r.wstrb);
          st_nxt.cc_en = wtmp[DXC_CTRL_CC_EN];
          st_nxt.tc_en = wtmp[DXC_CTRL_TC_EN];
          st_nxt.prio = wtmp[DXC_CTRL_PRIO_LSB +: 3];
          start_req = wtmp[DXC_CTRL_START];
        end
        DXC_OFF_GAP: begin
          wtmp = dxc_merge({16'h0, st_r.gap}, st_r.wdata, st_r.wstrb);
          st_nxt.gap = wtmp[15:0];
        end
        DXC_OFF_DIM: begin
          wtmp = dxc_merge({st_r.sdc, st_r.fdb}, st_r.wdata, st_r.wstrb);
          st_nxt.fdb = wtmp[15:0];
          st_nxt.sdc = wtmp[31:16];
        end
        DXC_OFF_INDEX: begin
          wtmp = dxc_merge({st_r.didx, st_r.sidx}, st_r.wdata, st_r.wstrb);
          st_nxt.sidx = wtmp[15:0];
          st_nxt.didx = wtmp[31:16];
        end
        DXC_OFF_MODE: begin
          wtmp = dxc_merge({st_r.default_burst_size, 14'h0, st_r.dmode, st_r.smode}, st_r.wdata, st_r.wstrb);
          st_nxt.smode = wtmp[DXC_MODE_SRC];
          st_nxt.dmode = wtmp[DXC_MODE_DST];
          st_nxt.default_burst_size = wtmp[DXC_MODE_DBS_LSB +: 16];
        end
        DXC_OFF_SRC: st_nxt.src = dxc_merge(st_r.src, st_r.wdata, st_r.wstrb);
        DXC_OFF_DST: st_nxt.dst = dxc_merge(st_r.dst, st_r.wdata, st_r.wstrb);
        DXC_OFF_IRQ_MASK: begin
          wtmp = dxc_merge({29'h0, st_r.irq_mask}, st_r.wdata, st_r.wstrb);
          st_nxt.irq_mask = wtmp[DXC_IRQ_W-1:0];
        end
        DXC_OFF_CC_ST, DXC_OFF_TC_ST, DXC_OFF_IRQ_ST: begin
          st_nxt.bresp = DXC_RESP_OKAY;
        end
        default: st_nxt.bresp = DXC_RESP_SLVERR;
      endcase
    end
    // Read mux; status words show live controller state.
    unique case (s_axi_araddr)
      DXC_OFF_CTRL: rd_val = {21'h0, st_r.prio, 6'h0, st_r.tc_en, st_r.cc_en};
      DXC_OFF_GAP: rd_val = {16'h0, st_r.gap};
      DXC_OFF_DIM: rd_val = {st_r.sdc, st_r.fdb};
      DXC_OFF_INDEX: rd_val = {st_r.didx, st_r.sidx};
      DXC_OFF_MODE: rd_val = {st_r.default_burst_size, 14'h0, st_r.dmode, st_r.smode};
      DXC_OFF_SRC: rd_val = st_r.src;
      DXC_OFF_DST: rd_val = st_r.dst;
      DXC_OFF_CC_ST: rd_val = {28'h0, cc_compl_pending, cc_tr_active,
                               cc_queue_busy, cc_evt_pending};
      DXC_OFF_TC_ST: rd_val = {27'h0, tc_stop_ack, cc_stop_ack, st_r.lin,
                               (st_r.state == DXC_S_WR_CMD),
                               (st_r.state inside {DXC_S_RD_CMD, DXC_S_RD_DATA,
                                                   DXC_S_GAP})};
      DXC_OFF_IRQ_ST: rd_val = {29'h0, st_r.irq_st};
      DXC_OFF_IRQ_MASK: rd_val = {29'h0, st_r.irq_mask};
      default: rd_val = 32'h0000_0000;
    endcase
    if (s_axi_rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_val;
      st_nxt.rresp = (s_axi_araddr > DXC_OFF_IRQ_MASK || s_axi_araddr[1:0] != 2'h0) ?
                     DXC_RESP_SLVERR : DXC_RESP_OKAY;
      if (s_axi_araddr == DXC_OFF_IRQ_ST) begin
        irq_clr = st_r.irq_st;
      end
    end
    // Starts are refused while busy, disabled, or stopping.
    start_ok = start_req && st_r.tc_en && !tc_stop_req && (st_r.state == DXC_S_IDLE) &&
               (st_r.fdb != 16'h0000) && (st_r.sdc != 16'h0000);
    // The engine has no halt input: an emulation halt never pauses it.
    unique case (st_r.state)
      DXC_S_IDLE: begin
        if (start_ok) begin
          st_nxt.lin = lin_c;
          st_nxt.cmd_bytes = lin_c ? 32'(st_r.fdb) * 32'(st_r.sdc) : 32'(st_r.fdb);
          st_nxt.cmds_left = lin_c ? 16'h0001 : st_r.sdc;
          st_nxt.cur_src = st_r.src;
          st_nxt.cur_dst = st_r.dst;
          st_nxt.state = DXC_S_RD_CMD;
        end
      end
      DXC_S_RD_CMD: begin
        if (rcmd_ready) begin
          st_nxt.state = DXC_S_RD_DATA;
        end
      end
      DXC_S_RD_DATA: begin
        if (rdat_valid) begin
          st_nxt.wdat = rdat;
          st_nxt.state = DXC_S_WR_CMD;
        end
      end
      DXC_S_WR_CMD: begin
        if (wcmd_ready) begin
          st_nxt.cmds_left = st_r.cmds_left - 16'h0001;
          st_nxt.cur_src = st_r.smode ? st_r.cur_src : st_r.cur_src + 32'(st_r.sidx);
          st_nxt.cur_dst = st_r.dmode ? st_r.cur_dst : st_r.cur_dst + 32'(st_r.didx);
          st_nxt.gap_cnt = st_r.gap;
          if (st_r.cmds_left == 16'h0001) begin
            st_nxt.state = DXC_S_IDLE;
            irq_set[DXC_IRQ_DONE] = 1'b1;
          end else if (st_r.gap == 16'h0000) begin
            st_nxt.state = DXC_S_RD_CMD;
          end else begin
            st_nxt.state = DXC_S_GAP;
          end
        end
      end
      DXC_S_GAP: begin
        st_nxt.gap_cnt = st_r.gap_cnt - 16'h0001;
        if (st_r.gap_cnt == 16'h0001) begin
          st_nxt.state = DXC_S_RD_CMD;
        end
      end
    endcase
    irq_set[DXC_IRQ_CC_IDLE] = cc_if.ack_rise;
    irq_set[DXC_IRQ_TC_IDLE] = tc_if.ack_rise;
    // A new event wins over a read clear in the same cycle.
    st_nxt.irq_st = (st_r.irq_st & ~irq_clr) | irq_set;
  end

  // State register; dimension, index, mode bits and address words are deliberately left out of reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r.state <= DXC_S_IDLE;
      st_r.aw_have <= 1'b0;
      st_r.awaddr <= 8'h00;
      st_r.w_have <= 1'b0;
      st_r.wdata <= 32'h0000_0000;
      st_r.wstrb <= 4'h0;
      st_r.bvalid <= 1'b0;
      st_r.bresp <= DXC_RESP_OKAY;
      st_r.rvalid <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.rresp <= DXC_RESP_OKAY;
      st_r.cc_en <= 1'b0;
      st_r.tc_en <= 1'b0;
      st_r.prio <= DXC_RST_PRIO;
      st_r.gap <= DXC_RST_GAP;
      st_r.default_burst_size <= DXC_RST_DBS;
      st_r.cur_src <= 32'h0000_0000;
      st_r.cur_dst <= 32'h0000_0000;
      st_r.cmd_bytes <= 32'h0000_0000;
      st_r.wdat <= 32'h0000_0000;
      st_r.cmds_left <= 16'h0000;
      st_r.gap_cnt <= 16'h0000;
      st_r.lin <= 1'b0;
      st_r.irq_st <= 3'h0;
      st_r.irq_mask <= DXC_RST_IRQ_MASK;
    end else begin
      st_r <= st_nxt; // Dimension, index, mode bits and address words keep their value.
    end
  end

  // Port drive.
  assign s_axi_awready = !st_r.aw_have && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_have && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign rcmd_valid = (st_r.state == DXC_S_RD_CMD);
  assign rcmd_addr = st_r.cur_src;
  assign rcmd_bytes = st_r.cmd_bytes;
  assign wcmd_valid = (st_r.state == DXC_S_WR_CMD);
  assign wcmd_addr = st_r.cur_dst;
  assign wcmd_bytes = st_r.cmd_bytes;
  assign wcmd_data = st_r.wdat;
  assign cc_enable = st_r.cc_en;
  assign cc_stop_ack = cc_if.stop_ack;
  assign tc_stop_ack = tc_if.stop_ack;
  assign master_prio = st_r.prio;
  assign irq = |(st_r.irq_st & st_r.irq_mask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_LIN_ONE_CMD: assert property (start_ok && lin_c |=> st_r.cmds_left == 16'h0001 &&
      rcmd_bytes == 32'($past(st_r.fdb)) * 32'($past(st_r.sdc)))
    else $error("linearised request not issued as one command");
  AST_SPLIT_CMDS: assert property (start_ok && !lin_c |=>
      st_r.cmds_left == $past(st_r.sdc) && rcmd_bytes == 32'($past(st_r.fdb)))
    else $error("non-linear request not split per array");
  AST_GAP_TWO: assert property (wr_hs && st_r.cmds_left != 16'h0001 &&
      st_r.gap == 16'h0002 |=> !rcmd_valid ##1 !rcmd_valid ##1 rcmd_valid)
    else $error("read gap of two cycles not kept");
  AST_NO_GAP: assert property (wr_hs && st_r.cmds_left != 16'h0001 &&
      st_r.gap == 16'h0000 |=> rcmd_valid)
    else $error("read command delayed with zero gap");
  AST_WR_STABLE: assert property (wcmd_valid && !wcmd_ready |=>
      wcmd_valid && $stable(wcmd_data) && $stable(wcmd_addr))
    else $error("write command or its data changed before acceptance");
  AST_PRIO_RESET: assert property ($past(rst) |-> master_prio == 3'h0)
    else $error("master priority not zero after reset");
  AST_CC_IDLE: assert property (cc_stop_ack && !$past(cc_stop_ack) |->
      $past(!cc_evt_pending && !cc_queue_busy && !cc_tr_active && !cc_compl_pending))
    else $error("channel side idled with activity pending");
  AST_TC_IDLE: assert property (tc_stop_ack |-> ##[0:1] st_r.state == DXC_S_IDLE)
    else $error("transfer side idled while busy");
  AST_TC_NO_START: assert property (tc_stop_req |=> !rcmd_valid || $past(!tc_if.conds_ok))
    else $error("transfer started under a clock-stop request");

  COV_LIN: cover property (start_ok && lin_c);
  COV_SPLIT: cover property (start_ok && !lin_c ##[1:50] wr_hs);
  COV_GAP: cover property (st_r.state == DXC_S_GAP ##1 rcmd_valid);
  COV_STOP: cover property ($rose(cc_stop_ack) ##[0:20] $rose(tc_stop_ack));

endmodule : dxc_top

// ### dxc_top_bench.sv
// Self-checking bench for the transfer issue and idle block.
`timescale 1ns/1ps
module dxc_top_bench;
  import dxc_pkg::*;
  logic mclk, rst, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rcmd_addr, rcmd_bytes, rdat, wcmd_addr, wcmd_bytes;
  logic [31:0] wcmd_data, rd, last_bytes, n_rd, last_gap, gap_cnt;
  logic [31:0] last_raddr, last_waddr, last_wbytes, last_wdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic rcmd_valid, rcmd_ready, rdat_valid, wcmd_valid, wcmd_ready, cc_enable, irq, rv_d;
  logic cc_evt_pending, cc_queue_busy, cc_tr_active, cc_compl_pending;
  logic cc_stop_req, cc_stop_ack, tc_stop_req, tc_stop_ack;
  logic [2:0] master_prio;
  int fails, checks_done, i;

  dxc_top u_dxc_top (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rcmd_valid, .rcmd_ready, .rcmd_addr,
    .rcmd_bytes, .rdat_valid, .rdat, .wcmd_valid, .wcmd_ready, .wcmd_addr, .wcmd_bytes,
    .wcmd_data, .cc_evt_pending, .cc_queue_busy, .cc_tr_active, .cc_compl_pending,
    .cc_enable, .cc_stop_req, .cc_stop_ack, .tc_stop_req, .tc_stop_ack, .master_prio, .irq);
  dxc_bus_model u_dxc_bus_model (.mclk, .rst, .slow, .rcmd_valid, .rcmd_ready, .rdat_valid,
    .rdat, .wcmd_valid, .wcmd_ready);

  // Clock at 200 MHz.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Counts read commands, keeps the last accepted commands and times the read gap.
  always @(posedge mclk) begin
    rv_d <= rcmd_valid;
    if (rcmd_valid && rcmd_ready) begin
      n_rd <= n_rd + 1;
      last_bytes <= rcmd_bytes;
      last_raddr <= rcmd_addr;
    end
    if (wcmd_valid && wcmd_ready) begin
      gap_cnt <= 0;
      {last_waddr, last_wbytes, last_wdata} <= {wcmd_addr, wcmd_bytes, wcmd_data};
    end else if (!rcmd_valid) gap_cnt <= gap_cnt + 1;
    if (rcmd_valid && !rv_d) last_gap <= gap_cnt;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("Checks %0d, errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // A wait that used up its bound ends the run as a failure.
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      finish_test();
    end
  endtask : tmo

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    int k;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (k = 0; k < 100 && !(aw && w); k++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    for (k = 0; k < 100; k++) begin
      @(posedge mclk);
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 0;
    tmo(k, 100);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (k = 0; k < 100; k++) begin
      @(posedge mclk);
      if (s_axi_arready) break;
    end
    // Ready rises only after the address is taken, so back-to-back reads never
    // drive it twice in one time step.
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    for (k = 0; k < 100; k++) begin
      @(posedge mclk);
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
    tmo(k, 100);
  endtask : axr

  // Parameters are all written before the start, since dimension, index, mode bits and addresses hold no reset value.
  task automatic xfer(input logic [31:0] dim, idx, input logic [1:0] md,
                      input logic [15:0] gap, input logic sl, input logic [31:0] n, b);
    logic [31:0] n0;
    int k;
    slow <= sl;
    axw(DXC_OFF_GAP, {16'h0, gap});
    axw(DXC_OFF_DIM, dim);
    axw(DXC_OFF_INDEX, idx);
    axw(DXC_OFF_MODE, {DXC_RST_DBS, 14'h0, md});
    axw(DXC_OFF_SRC, 32'h1000_0000);
    axw(DXC_OFF_DST, 32'h2000_0000);
    n0 = n_rd;
    axw(DXC_OFF_CTRL, 32'h6);
    for (k = 0; k < 20000 && irq !== 1'b1; k++) @(posedge mclk);
    tmo(k, 20000);
    chk(n_rd - n0, n);
    chk(last_bytes, b);
    chk(last_wbytes, b);
    chk(last_wdata, 32'hc0de_0001);
    chk(last_raddr, 32'h1000_0000 + (md[0] ? 32'h0 : (n - 1) * idx[15:0]));
    chk(last_waddr, 32'h2000_0000 + (md[1] ? 32'h0 : (n - 1) * idx[31:16]));
    if (n > 1) chk(last_gap, {16'h0, gap});
    axr(DXC_OFF_TC_ST);
    chk(rd[2], n == 1);
    axr(DXC_OFF_IRQ_ST);
    chk(rd[0], 1'b1);
    chk(irq, 1'b0);
  endtask : xfer

  initial begin
    {rst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {cc_evt_pending, cc_queue_busy, cc_tr_active, cc_compl_pending} = 4'h0;
    {cc_stop_req, tc_stop_req, n_rd, gap_cnt, last_gap, last_bytes} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    chk(master_prio, 3'h0);
    axr(DXC_OFF_GAP);
    chk(rd, 32'h0);
    axr(DXC_OFF_MODE);
    chk(rd[31:16], DXC_RST_DBS);
    axr(8'h40);
    chk(resp, DXC_RESP_SLVERR);
    axw(8'h40, 32'h1);
    chk(resp, DXC_RESP_SLVERR);
    // Status lines are read back before any clock stop is asked for.
    for (i = 0; i < 2; i++) begin
      {cc_compl_pending, cc_tr_active, cc_queue_busy, cc_evt_pending} <= i ? 4'h6 : 4'h9;
      axr(DXC_OFF_CC_ST);
      chk(rd[3:0], i ? 4'h6 : 4'h9);
    end
    cc_stop_req <= 1;
    tc_stop_req <= 1;
    repeat (5) @(posedge mclk);
    chk(cc_stop_ack, 1'b0);
    chk(tc_stop_ack, 1'b1);
    {cc_compl_pending, cc_tr_active, cc_queue_busy, cc_evt_pending} <= 4'h0;
    for (i = 0; i < 50 && cc_stop_ack !== 1'b1; i++) @(posedge mclk);
    tmo(i, 50);
    cc_stop_req <= 0;
    repeat (2) @(posedge mclk);
    chk(cc_stop_ack, 1'b0);
    chk(tc_stop_ack, 1'b1);
    tc_stop_req <= 0;
    repeat (2) @(posedge mclk);
    chk(tc_stop_ack, 1'b0);
    // Power-down order would disable the channel side first; here only done is unmasked.
    axw(DXC_OFF_IRQ_MASK, 32'h1);
    chk(resp, DXC_RESP_OKAY);
    // The start bit is gated by the enable already held, so enable first.
    axw(DXC_OFF_CTRL, 32'h2);
    chk(resp, DXC_RESP_OKAY);
    xfer({16'd8, 16'd4}, {16'd4, 16'd4}, 2'b00, 16'd0, 1'b0, 1, 32);
    xfer({16'd1023, 16'd4}, {16'd4, 16'd4}, 2'b00, 16'd0, 1'b1, 1, 4092);
    xfer({16'd2, 16'd64}, {16'd64, 16'd64}, 2'b00, 16'd0, 1'b0, 1, 128);
    xfer({16'd1024, 16'd4}, {16'd4, 16'd4}, 2'b00, 16'd0, 1'b0, 1024, 4);
    xfer({16'd3, 16'd4}, {16'd4, 16'd4}, 2'b01, 16'd3, 1'b1, 3, 4);
    xfer({16'd2, 16'd4}, {16'd4, 16'd4}, 2'b10, 16'd1, 1'b0, 2, 4);
    xfer({16'd2, 16'd6}, {16'd6, 16'd6}, 2'b00, 16'd0, 1'b0, 2, 6);
    xfer({16'd2, 16'd4}, {16'd4, 16'd8}, 2'b00, 16'd0, 1'b0, 2, 4);
    xfer({16'd2, 16'd128}, {16'd128, 16'd128}, 2'b00, 16'd2, 1'b1, 2, 128);
    // A second reset mid-run must drop the programmed priority and gap.
    axw(DXC_OFF_CTRL, 32'h303);
    chk(master_prio, 3'h3);
    chk(cc_enable, 1'b1);
    axw(DXC_OFF_GAP, 32'h5);
    rst <= 1;
    repeat (2) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    chk(master_prio, 3'h0);
    chk(cc_enable, 1'b0);
    axr(DXC_OFF_GAP);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : dxc_top_bench
